// file: ag3d_chk_assertions.sv
// checker for stream latency, frame update and 3d pulse timing
`timescale 1ns/1ns
module ag3d_chk #(
  parameter PULSE_CYC = 625
) (
  input wire        clk,
  input wire        rst_n,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        pix_valid,
  input wire        pix_sof,
  input wire        out_valid,
  input wire [7:0]  led_pwr_r,
  input wire [7:0]  led_pwr_g,
  input wire [7:0]  led_pwr_b,
  input wire        led_update,
  input wire        light_pulse_req,
  input wire        light_enable
);
  // counts cycles of the current light pulse
  reg [15:0] wid_reg;
  always @(posedge clk) begin
    if (!rst_n)
      wid_reg <= 16'h0;
    else
      wid_reg <= light_pulse_req ? wid_reg + 16'h1 : 16'h0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_out_lat; pix_valid |=> out_valid; endproperty
  a_out_lat: assert property (p_out_lat) else $error("no pixel out");
  property p_out_idle; !pix_valid |=> !out_valid; endproperty
  a_out_idle: assert property (p_out_idle) else $error("stray out");
  property p_led_hold;
    $changed(led_pwr_r) || $changed(led_pwr_g) || $changed(led_pwr_b)
      |-> led_update;
  endproperty
  a_led_hold: assert property (p_led_hold)
    else $error("led mid frame");
  property p_upd_cause; pix_valid && pix_sof |=> led_update; endproperty
  a_upd_cause: assert property (p_upd_cause)
    else $error("no update");
  property p_upd_only; led_update |-> $past(pix_sof) && $past(pix_valid);
  endproperty
  a_upd_only: assert property (p_upd_only)
    else $error("stray update");
  // the pulse is lit, and the source is dark just before it
  property p_pulse_dark;
    $rose(light_pulse_req) |-> !$past(light_enable) && light_enable;
  endproperty
  a_pulse_dark: assert property (p_pulse_dark)
    else $error("pulse not framed by dark");
  property p_dark_after; $fell(light_pulse_req) |-> !light_enable;
  endproperty
  a_dark_after: assert property (p_dark_after)
    else $error("lit after pulse");
  property p_pulse_wid; $fell(light_pulse_req) |-> wid_reg == PULSE_CYC;
  endproperty
  a_pulse_wid: assert property (p_pulse_wid)
    else $error("pulse width");
  property p_pulse_gap; $fell(light_pulse_req) |=> !light_pulse_req[*8];
  endproperty
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("double pulse");
  property p_rd_stand; reg_rdata != 16'h0 |-> $past(reg_rd); endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("stray rdata");
endmodule

// file: ag3d_map.vh
// register map, field positions and timing constants for the gain/3d block
`ifndef AG3D_MAP_VH
`define AG3D_MAP_VH

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define AG3D_REG_CTRL     4'h0
`define AG3D_REG_CLIP     4'h1
`define AG3D_REG_MINBIN   4'h2
`define AG3D_REG_TGT_R    4'h3
`define AG3D_REG_TGT_G    4'h4
`define AG3D_REG_TGT_B    4'h5
`define AG3D_REG_STRENGTH 4'h6
`define AG3D_REG_GAIN_RG  4'h7
`define AG3D_REG_GAIN_B   4'h8
`define AG3D_REG_LED_RG   4'h9
`define AG3D_REG_LED_B    4'ha

// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define AG3D_CTRL_CONTENT_ADAPTIVE_ILLUMINATION_EN  0
`define AG3D_CTRL_ENHANCE  1
`define AG3D_CTRL_BOOST_EN 2
`define AG3D_CTRL_SYNC_EN  3
`define AG3D_CTRL_LIGHT    4
`define AG3D_CTRL_SUB4     5
`define AG3D_CTRL_W        6
`define AG3D_CTRL_RST      6'h00
`define AG3D_CLIP_RST      16'h0040
`define AG3D_MINBIN_RST    3'h0
`define AG3D_TGT_RST       8'hc0
`define AG3D_STRENGTH_RST  5'h08

// ------------------------------------------------------------
// datapath constants
// ------------------------------------------------------------
`define AG3D_UNITY     8'h20
`define AG3D_GAIN_SH   5
`define AG3D_TOP_BIN   3'h7
`define AG3D_AREA_LSB  8
`define AG3D_CNT_MAX   16'hffff

// ------------------------------------------------------------
// timing: clock rate and nominal 3d pulse times in microseconds
// ------------------------------------------------------------
`define AG3D_CLK_MHZ   25
`define AG3D_PULSE_US  25
`define AG3D_DARK_US   628
`define AG3D_OFFS_US   500
`define AG3D_DELTA_US  128

`endif

// file: ag3d_pix_src.sv
// pixel source model: free-running one-line frames in two colour zones
`timescale 1ns/1ns
module ag3d_pix_src (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [15:0] line_len,
  input  wire [23:0] val_lo,
  input  wire [23:0] val_hi,
  output reg         pix_valid,
  output wire        pix_sof,
  output wire        pix_sol,
  output wire [7:0]  pix_r,
  output wire [7:0]  pix_g,
  output wire [7:0]  pix_b
);
  reg  [15:0] col_reg;
  wire [15:0] col_next = col_reg + 16'h1;
  wire [23:0] val = (col_reg < 16'h0100) ? val_lo : val_hi;

  // runs while a line length is set; a shorter length wraps at once
  always @(posedge clk) begin
    if (!rst_n) begin
      pix_valid <= 1'b0;
      col_reg   <= 16'h0;
    end else begin
      pix_valid <= (line_len != 16'h0);
      if (pix_valid)
        col_reg <= (col_next >= line_len) ? 16'h0 : col_next;
    end
  end

  // frame and line start on column zero; idle data is inverted
  assign pix_sof = pix_valid & (col_reg == 16'h0);
  assign pix_sol = pix_sof;
  assign {pix_r, pix_g, pix_b} = pix_valid ? val : ~val;
endmodule

// file: ag3d_top.v
// adaptive channel gain, local area boost and 3d left/right sync generator
// Overview of operation
// - per frame, red, green, blue gains; each pixel times its channel gain
// - gain lifts channel toward full scale, stopping where few pixels clip
// - per colour, set led power together with gain under host settings
// - keep resulting colour balance at the configured target every frame
// - power-reduction mode holds brightness; enhanced mode holds led power
// - per frame local area gains; areas dimmer than frame average get more
// - host boost strength scales local gains, updatable once per frame
// - output left/right sync pin timed to dmd subframes for ir emitter
// - light sync asks driver for one pulse per subframe, shutters closed
// - light source stays off in the closed interval except the sync pulse
// - pulse spacing alternates subframe period plus and minus the delta
// - dmd subframe rate follows source frame rate, two or four per frame
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "ag3d_map.vh"
module ag3d_top #(
  parameter PULSE_CYC = `AG3D_PULSE_US * `AG3D_CLK_MHZ,
  parameter DARK_CYC  = `AG3D_DARK_US  * `AG3D_CLK_MHZ,
  parameter OFFS_CYC  = `AG3D_OFFS_US  * `AG3D_CLK_MHZ,
  parameter DELTA_CYC = `AG3D_DELTA_US * `AG3D_CLK_MHZ
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        pix_valid,
  input  wire        pix_sof,
  input  wire        pix_sol,
  input  wire [7:0]  pix_r,
  input  wire [7:0]  pix_g,
  input  wire [7:0]  pix_b,
  output reg         out_valid,
  output reg  [7:0]  out_r,
  output reg  [7:0]  out_g,
  output reg  [7:0]  out_b,
  output reg  [7:0]  led_pwr_r,
  output reg  [7:0]  led_pwr_g,
  output reg  [7:0]  led_pwr_b,
  output reg         led_update,
  output reg         lr_sync_out,
  output reg         light_pulse_req,
  output reg         light_enable
);
  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // gain in q3.5 that maps top of bin b to full scale
  function [7:0] bin_gain;
    input [2:0] b;
    begin
      case (b)
        3'h0:    bin_gain = 8'hff;
        3'h1:    bin_gain = 8'h80;
        3'h2:    bin_gain = 8'h55;
        3'h3:    bin_gain = 8'h40;
        3'h4:    bin_gain = 8'h33;
        3'h5:    bin_gain = 8'h2b;
        3'h6:    bin_gain = 8'h25;
        default: bin_gain = `AG3D_UNITY;
      endcase
    end
  endfunction

  // saturating pixel times q3.5 gain
  function [7:0] sat_mul;
    input [7:0] p;
    input [7:0] g;
    reg   [15:0] m;
    begin
      m = p * g;
      if (m[15:13] != 3'h0)
        sat_mul = 8'hff;
      else
        sat_mul = m[12:5];
    end
  endfunction
  // led power lowered by the inverse of the bin gain
  function [7:0] led_scale;
    input [7:0] t;
    input [2:0] b;
    reg   [10:0] m;
    begin
      m = t * ({1'b0, b} + 4'h1);
      led_scale = m[10:3];
    end
  endfunction

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [`AG3D_CTRL_W-1:0] ctrl_reg;
  reg [15:0] clip_reg;
  reg [2:0]  minbin_reg;
  reg [7:0]  tgt_r_reg;
  reg [7:0]  tgt_g_reg;
  reg [7:0]  tgt_b_reg;
  reg [4:0]  strength_reg;
  reg [7:0]  gain_r_reg;
  reg [7:0]  gain_g_reg;
  reg [7:0]  gain_b_reg;

  // host writes; one word per index
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg     <= `AG3D_CTRL_RST;
      clip_reg     <= `AG3D_CLIP_RST;
      minbin_reg   <= `AG3D_MINBIN_RST;
      tgt_r_reg    <= `AG3D_TGT_RST;
      tgt_g_reg    <= `AG3D_TGT_RST;
      tgt_b_reg    <= `AG3D_TGT_RST;
      strength_reg <= `AG3D_STRENGTH_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `AG3D_REG_CTRL:     ctrl_reg     <= reg_wdata[`AG3D_CTRL_W-1:0];
        `AG3D_REG_CLIP:     clip_reg     <= reg_wdata;
        `AG3D_REG_MINBIN:   minbin_reg   <= reg_wdata[2:0];
        `AG3D_REG_TGT_R:    tgt_r_reg    <= reg_wdata[7:0];
        `AG3D_REG_TGT_G:    tgt_g_reg    <= reg_wdata[7:0];
        `AG3D_REG_TGT_B:    tgt_b_reg    <= reg_wdata[7:0];
        `AG3D_REG_STRENGTH: strength_reg <= reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always @(posedge clk) begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd) begin
      case (reg_addr)
        `AG3D_REG_CTRL:     reg_rdata <= {10'h000, ctrl_reg};
        `AG3D_REG_CLIP:     reg_rdata <= clip_reg;
        `AG3D_REG_MINBIN:   reg_rdata <= {13'h0000, minbin_reg};
        `AG3D_REG_TGT_R:    reg_rdata <= {8'h00, tgt_r_reg};
        `AG3D_REG_TGT_G:    reg_rdata <= {8'h00, tgt_g_reg};
        `AG3D_REG_TGT_B:    reg_rdata <= {8'h00, tgt_b_reg};
        `AG3D_REG_STRENGTH: reg_rdata <= {11'h000, strength_reg};
        `AG3D_REG_GAIN_RG:  reg_rdata <= {gain_g_reg, gain_r_reg};
        `AG3D_REG_GAIN_B:   reg_rdata <= {8'h00, gain_b_reg};
        `AG3D_REG_LED_RG:   reg_rdata <= {led_pwr_g, led_pwr_r};
        `AG3D_REG_LED_B:    reg_rdata <= {8'h00, led_pwr_b};
        default:            reg_rdata <= 16'h0000;
      endcase
    end else
      reg_rdata <= 16'h0000;
  end

  // ------------------------------------------------------------
  // frame statistics: per-channel top-bit histograms, area sums
  // ------------------------------------------------------------
  reg  [15:0] hist [0:23];     // index channel*8 + bin
  reg  [31:0] area_sum [0:7];
  reg  [31:0] frame_sum;
  reg  [11:0] col_reg;
  wire        sof_px = pix_valid & pix_sof;
  wire [9:0]  luma = {2'h0, pix_r} + {1'h0, pix_g, 1'h0} + {2'h0, pix_b};
  wire [2:0]  area_in = pix_sol ? 3'h0
                      : col_reg[`AG3D_AREA_LSB+2:`AG3D_AREA_LSB];
  integer i;
  // a first pixel restarts all statistics and is counted itself
  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < 24; i = i + 1)
        hist[i] <= 16'h0000;
      for (i = 0; i < 8; i = i + 1)
        area_sum[i] <= 32'h00000000;
      frame_sum <= 32'h00000000;
      col_reg   <= 12'h000;
    end else if (pix_valid) begin
      col_reg <= (pix_sol | pix_sof) ? 12'h001 : col_reg + 12'h001;
      for (i = 0; i < 24; i = i + 1) begin
        if (((i / 8) == 0 && pix_r[7:5] == i[2:0]) ||
            ((i / 8) == 1 && pix_g[7:5] == i[2:0]) ||
            ((i / 8) == 2 && pix_b[7:5] == i[2:0]))
          hist[i] <= sof_px ? 16'h0001
                   : (hist[i] == `AG3D_CNT_MAX ? hist[i] : hist[i] + 16'h0001);
        else if (sof_px)
          hist[i] <= 16'h0000;
      end
      for (i = 0; i < 8; i = i + 1) begin
        if (area_in == i[2:0])
          area_sum[i] <= (sof_px ? 32'h00000000 : area_sum[i])
                       + {22'h000000, luma};
        else if (sof_px)
          area_sum[i] <= 32'h00000000;
      end
      frame_sum <= (sof_px ? 32'h00000000 : frame_sum) + {22'h000000, luma};
    end
  end

  // lowest bin whose pixels above stay within the clip limit
  reg [2:0]  bin_sel [0:2];
  reg [17:0] above;
  integer c;
  integer b;
  always @* begin
    above = 18'h00000;
    for (c = 0; c < 3; c = c + 1) begin
      bin_sel[c] = `AG3D_TOP_BIN;
      above = 18'h00000;
      for (b = 7; b >= 0; b = b - 1) begin
        if (b < 7)
          above = above + {2'h0, hist[c * 8 + b + 1]};
        if (above <= {2'h0, clip_reg})
          bin_sel[c] = b[2:0];
      end
      if (bin_sel[c] < minbin_reg)
        bin_sel[c] = minbin_reg;
      if (!ctrl_reg[`AG3D_CTRL_CONTENT_ADAPTIVE_ILLUMINATION_EN])
        bin_sel[c] = `AG3D_TOP_BIN;
    end
  end

  // enhanced mode shares the weakest gain so balance and power hold
  wire [2:0] bin_rg  = (bin_sel[0] > bin_sel[1]) ? bin_sel[0] : bin_sel[1];
  wire [2:0] bin_com = (bin_rg > bin_sel[2]) ? bin_rg : bin_sel[2];
  wire       enh     = ctrl_reg[`AG3D_CTRL_ENHANCE];
  wire [2:0] use_r   = enh ? bin_com : bin_sel[0];
  wire [2:0] use_g   = enh ? bin_com : bin_sel[1];
  wire [2:0] use_b   = enh ? bin_com : bin_sel[2];

  // ------------------------------------------------------------
  // frame-boundary update of gains and led powers
  // ------------------------------------------------------------
  reg  [7:0]  area_gain [0:7];
  wire [4:0]  half_str = {1'h0, strength_reg[4:1]};
  integer a;
  always @(posedge clk) begin
    if (!rst_n) begin
      gain_r_reg <= `AG3D_UNITY;
      gain_g_reg <= `AG3D_UNITY;
      gain_b_reg <= `AG3D_UNITY;
      led_pwr_r  <= `AG3D_TGT_RST;
      led_pwr_g  <= `AG3D_TGT_RST;
      led_pwr_b  <= `AG3D_TGT_RST;
      led_update <= 1'b0;
      for (a = 0; a < 8; a = a + 1)
        area_gain[a] <= `AG3D_UNITY;
    end else begin
      led_update <= sof_px;
      if (sof_px) begin
        gain_r_reg <= bin_gain(use_r);
        gain_g_reg <= bin_gain(use_g);
        gain_b_reg <= bin_gain(use_b);
        // power mode lowers led by the gain, enhanced mode keeps target
        led_pwr_r  <= enh ? tgt_r_reg : led_scale(tgt_r_reg, use_r);
        led_pwr_g  <= enh ? tgt_g_reg : led_scale(tgt_g_reg, use_g);
        led_pwr_b  <= enh ? tgt_b_reg : led_scale(tgt_b_reg, use_b);
        for (a = 0; a < 8; a = a + 1) begin
          if (!ctrl_reg[`AG3D_CTRL_BOOST_EN])
            area_gain[a] <= `AG3D_UNITY;
          else if ({area_sum[a][30:0], 4'h0} < {3'h0, frame_sum})
            area_gain[a] <= `AG3D_UNITY + {3'h0, strength_reg};
          else if ({area_sum[a][31:0], 3'h0} < {3'h0, frame_sum})
            area_gain[a] <= `AG3D_UNITY + {3'h0, half_str};
          else
            area_gain[a] <= `AG3D_UNITY;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // pixel path: channel gain then local area gain
  // ------------------------------------------------------------
  wire [7:0] ag = area_gain[area_in];
  always @(posedge clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_r     <= 8'h00;
      out_g     <= 8'h00;
      out_b     <= 8'h00;
    end else begin
      out_valid <= pix_valid;
      out_r     <= sat_mul(sat_mul(pix_r, gain_r_reg), ag);
      out_g     <= sat_mul(sat_mul(pix_g, gain_g_reg), ag);
      out_b     <= sat_mul(sat_mul(pix_b, gain_b_reg), ag);
    end
  end

  // ------------------------------------------------------------
  // 3d sync: subframe timing and pulse placement
  // ------------------------------------------------------------
  reg  [23:0] fcnt_reg;
  reg  [23:0] flen_reg;
  reg  [23:0] scnt_reg;
  reg         eye_reg;
  wire [23:0] sub_len = ctrl_reg[`AG3D_CTRL_SUB4] ? {2'h0, flen_reg[23:2]}
                                                  : {1'h0, flen_reg[23:1]};
  wire        sub_end = (scnt_reg + 24'h000001 >= sub_len);
  wire [23:0] pos     = OFFS_CYC[23:0] + (eye_reg ? DELTA_CYC[23:0] : 24'h0);
  wire        in_pulse = (scnt_reg >= pos) &&
                         (scnt_reg < pos + PULSE_CYC[23:0]);
  wire        in_dark  = scnt_reg < DARK_CYC[23:0] + DELTA_CYC[23:0];
  wire        sync_en  = ctrl_reg[`AG3D_CTRL_SYNC_EN];
  wire        light_md = ctrl_reg[`AG3D_CTRL_LIGHT];
  // subframes divide the measured source frame
  always @(posedge clk) begin
    if (!rst_n) begin
      fcnt_reg <= 24'h000000;
      flen_reg <= 24'h000000;
      scnt_reg <= 24'h000000;
      eye_reg  <= 1'b0;
    end else if (sof_px) begin
      flen_reg <= fcnt_reg + 24'h000001;
      fcnt_reg <= 24'h000000;
      scnt_reg <= 24'h000000;
      eye_reg  <= 1'b0;
    end else begin
      fcnt_reg <= fcnt_reg + 24'h000001;
      if (sub_end) begin
        scnt_reg <= 24'h000000;
        eye_reg  <= ~eye_reg;
      end else
        scnt_reg <= scnt_reg + 24'h000001;
    end
  end

  // sync outputs
  always @(posedge clk) begin
    if (!rst_n) begin
      lr_sync_out     <= 1'b0;
      light_pulse_req <= 1'b0;
      light_enable    <= 1'b1;
    end else begin
      lr_sync_out     <= sync_en & ~light_md & eye_reg;
      light_pulse_req <= sync_en & light_md & in_pulse;
      light_enable    <= ~(sync_en & light_md) | ~in_dark | in_pulse;
    end
  end
endmodule

// file: tb_adaptive_gain_and_3d_sync.sv
// self-checking bench for the adaptive gain and 3d sync block
`timescale 1ns/1ns
module tb_adaptive_gain_and_3d_sync;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] line_len = 16'h0;
  logic [23:0] val_lo = 24'h0;
  logic [23:0] val_hi = 24'h0;
  wire  [15:0] reg_rdata;
  wire  [7:0]  pix_r, pix_g, pix_b, out_r, out_g, out_b;
  wire  [7:0]  led_pwr_r, led_pwr_g, led_pwr_b;
  wire         pix_valid, pix_sof, pix_sol, out_valid, led_update;
  wire         lr_sync_out, light_pulse_req, light_enable;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          hits = 0;

  // short 3d times: pulse 5, dark 40, offset 20, delta 8 cycles
  ag3d_top #(.PULSE_CYC(5), .DARK_CYC(40), .OFFS_CYC(20),
    .DELTA_CYC(8)) i_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_sol(pix_sol),
    .pix_r(pix_r), .pix_g(pix_g), .pix_b(pix_b), .out_valid(out_valid),
    .out_r(out_r), .out_g(out_g), .out_b(out_b), .led_pwr_r(led_pwr_r),
    .led_pwr_g(led_pwr_g), .led_pwr_b(led_pwr_b), .led_update(led_update),
    .lr_sync_out(lr_sync_out), .light_pulse_req(light_pulse_req),
    .light_enable(light_enable));
  ag3d_pix_src i_src (.clk(clk), .rst_n(rst_n), .line_len(line_len),
    .val_lo(val_lo), .val_hi(val_hi), .pix_valid(pix_valid),
    .pix_sof(pix_sof), .pix_sol(pix_sol), .pix_r(pix_r), .pix_g(pix_g),
    .pix_b(pix_b));

  // clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------
  // bus, compare and wait helpers
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk("reg_rdata", {8'h0, exp}, {8'h0, reg_rdata});
  endtask
  // waits n frame starts, returns when pixel 1 of the frame shows
  task automatic sof(input int n);
    repeat (n) begin
      do @(posedge clk); while (!(pix_valid && pix_sof));
    end
    @(posedge clk);
    @(posedge clk);
  endtask
  // cycles to next eye toggle (lr) or next light pulse start
  task automatic ev(input bit lr, output int n);
    logic p, c;
    n = 0;
    c = lr ? lr_sync_out : light_pulse_req;
    do begin
      p = c;
      @(posedge clk);
      n++;
      c = lr ? lr_sync_out : light_pulse_req;
      if (light_pulse_req !== 1'b0) hits++;
    end while (lr ? c === p : !(c === 1'b1 && p === 1'b0));
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    logic [15:0] e [16] = '{16'h0, 16'h40, 16'h0, 16'hc0, 16'hc0, 16'hc0,
      16'h8, 16'h2020, 16'h20, 16'hc0c0, 16'hc0, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0};
    for (int i = 0; i < 16; i++) rd(4'(i), e[i]);
    wr(4'h7, 16'hffff);
    rd(4'h7, 16'h2020);
    chk("led_pwr", 24'hc0c0c0, {led_pwr_r, led_pwr_g, led_pwr_b});
  endtask
  task automatic t_power;
    wr(4'h0, 16'h0001);
    val_lo <= 24'h3070f0;
    val_hi <= 24'h3070f0;
    line_len <= 16'h00c8;
    sof(2);
    chk("out_rgb", 24'hc0e0f0, {out_r, out_g, out_b});
    chk("led_pwr", 24'h3060c0, {led_pwr_r, led_pwr_g, led_pwr_b});
    rd(4'h7, 16'h4080);
    rd(4'h9, 16'h6030);
    wr(4'h1, 16'h00c8);
    sof(2);
    chk("out_clip", 24'hff, {16'h0, out_r});
    chk("led_clip", 24'h18, {16'h0, led_pwr_r});
    wr(4'h2, 16'h0002);
    sof(1);
    chk("out_minbin", 24'h7f, {16'h0, out_r});
    chk("led_minbin", 24'h48, {16'h0, led_pwr_r});
    wr(4'h2, 16'h0000);
    wr(4'h1, 16'h0040);
  endtask
  task automatic t_enh;
    wr(4'h0, 16'h0003);
    val_lo <= 24'h303050;
    val_hi <= 24'h303050;
    sof(2);
    chk("out_rgb", 24'h7f7fd4, {out_r, out_g, out_b});
    chk("led_pwr", 24'hc0c0c0, {led_pwr_r, led_pwr_g, led_pwr_b});
  endtask
  task automatic t_boost;
    logic [7:0]  s [3] = '{8'h00, 8'h08, 8'h10};
    logic [15:0] x;
    wr(4'h0, 16'h0004);
    val_lo <= 24'hffffff;
    val_hi <= 24'h101010;
    line_len <= 16'h0200;
    foreach (s[i]) begin
      wr(4'h6, {8'h0, s[i]});
      sof(2);
      chk("out_bright", 24'hffffff, {out_r, out_g, out_b});
      repeat (299) @(posedge clk);
      x = (16'h10 * (16'h20 + {8'h0, s[i]})) >> 5;
      chk("out_dim", {3{x[7:0]}}, {out_r, out_g, out_b});
    end
  endtask
  task automatic t_sync;
    int a, b, c;
    wr(4'h0, 16'h0008);
    line_len <= 16'h00c8;
    sof(3);
    chk("lr_at_sof", 24'h0, {23'h0, lr_sync_out});
    hits = 0;
    ev(1'b1, a);
    ev(1'b1, b);
    chk("lr_period", 24'h64, 24'(b));
    chk("ir_pulses", 24'h0, 24'(hits));
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, k ? 16'h0038 : 16'h0018);
      sof(3);
      ev(1'b0, a);
      ev(1'b0, b);
      ev(1'b0, c);
      chk("pulse_pair", k ? 24'h64 : 24'hc8, 24'(b + c));
      chk("pulse_skew", 24'h10, 24'(b > c ? b - c : c - b));
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // reset for 5 cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_power();
    t_enh();
    t_boost();
    t_sync();
    give_verdict();
  end
endmodule

bind ag3d_top ag3d_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pix_valid(pix_valid), .pix_sof(pix_sof), .out_valid(out_valid),
  .led_pwr_r(led_pwr_r), .led_pwr_g(led_pwr_g), .led_pwr_b(led_pwr_b),
  .led_update(led_update), .light_pulse_req(light_pulse_req),
  .light_enable(light_enable));
